// ==== logic/sadc_readout.sv ====
// Conversion and serial readout sequencer of the 16-bit sampling converter
// Functional notes
// - Output bits change on serial clock falling edge
// - Select falling starts sample, convert, transfer
// - First 4.5 to 5 periods acquire input
// - Fifth falling edge drives low start bit
// - Sixteen result bits follow, MSB first
// - Further clocks repeat result LSB first
// - After repeated MSB, tri-state, ignore clocks
// - New conversion only after select high then low
// - Result is unsigned straight binary
// - Power down after conversion or select high
// - Select low powers down analog only
// - Analog powered from cycle start until power-down
// - Each bit output as soon as decided
// - Select high aborts conversion anytime, powers down
`timescale 1ns/1ps
`include "sadc_regs.svh"
module sadc_readout
   import sadc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic serial_bit_clock_i,
   input wire logic cs_n_i,
   input wire logic cmp_i,
   output logic [`SADC_RES_W-1:0] dac_code_o,
   output logic sample_o,
   output logic analog_pwr_o,
   output logic digital_pwr_o,
   output logic dout_o,
   output logic dout_oe_n_o
);
   sadc_state_t state; // Current phase
   sadc_state_t next_state; // Phase after this cycle
   logic [`SADC_CNT_W-1:0] cnt; // Falling edges seen since select fell
   logic [`SADC_CNT_W-1:0] next_cnt; // Counter value after this cycle
   logic [`SADC_CNT_W-1:0] fall_num; // Number of the falling edge now seen
   logic next_dout; // Serial data after this cycle
   logic next_oe_n; // Output enable after this cycle
   logic clk_fall_raw; // Serial clock falling, select ignored
   logic bit_fall; // Serial clock falling while selected
   logic cs_rise; // Select released
   logic cs_fall; // Select asserted
   logic conv_fall; // Falling edge that decides a result bit
   logic rep_fall; // Falling edge that repeats a result bit
   logic [`SADC_IDX_W-1:0] conv_idx; // Bit decided on this edge
   logic [`SADC_IDX_W-1:0] rep_idx; // Bit repeated on this edge
   logic [`SADC_RES_W-1:0] result; // Decided result bits
   logic sar_clear; // Restart the approximation

   // Serial clock edges; clock level before reset is taken as high
   sadc_edge u_clk_edge (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .sig_i(serial_bit_clock_i),
      .reset_level_i(1'b0),
      .rise_o(),
      .fall_o(clk_fall_raw)
   );

   // Select edges; select level before reset is taken as high, so a held-low select counts as a fall
   sadc_edge u_cs_edge (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .sig_i(cs_n_i),
      .reset_level_i(1'b0),
      .rise_o(cs_rise),
      .fall_o(cs_fall)
   );

   // Edge decode; clocks count only while selected and not finished
   assign bit_fall = clk_fall_raw & ~cs_n_i & (state != SADC_IDLE) &
                     (state != SADC_DONE);
   assign fall_num = cnt + `SADC_CNT_ONE;
   assign conv_fall = bit_fall && (fall_num >= `SADC_MSB_FALL) &&
                      (fall_num <= `SADC_LSB_FALL);
   assign rep_fall = bit_fall && (fall_num > `SADC_LSB_FALL) &&
                     (fall_num <= `SADC_LAST_FALL);
   assign conv_idx = `SADC_IDX_W'(`SADC_LSB_FALL - fall_num);
   assign rep_idx = `SADC_IDX_W'(fall_num - `SADC_LSB_FALL);
   assign sar_clear = cs_n_i | cs_fall;

   // Approximation register; the DAC code is its trial word
   sadc_sar u_sar (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .clear_i(sar_clear),
      .decide_i(conv_fall),
      .bit_idx_i(conv_idx),
      .cmp_i(cmp_i),
      .trial_o(dac_code_o),
      .result_o(result)
   );

   // Sampling and analog power follow the phase; digital power follows select
   assign sample_o = (state == SADC_ACQ);
   // Analog stays on from select fall until the LSB is decided
   assign analog_pwr_o = (state == SADC_ACQ) || (state == SADC_START) ||
                         (state == SADC_CONV);
   // Digital section sleeps only while select is high
   assign digital_pwr_o = ~cs_n_i;

   // Falling-edge counter, cleared whenever select is high or just fell
   always_comb begin
      next_cnt = cnt;
      if (cs_n_i || cs_fall) begin
         next_cnt = `SADC_CNT_ZERO;
      end else if (bit_fall) begin
         next_cnt = fall_num;
      end
   end

   // Phase sequencing
   always_comb begin
      next_state = state;
      unique case (state)
         SADC_IDLE: begin
            if (cs_fall) begin
               next_state = SADC_ACQ;
            end
         end
         SADC_ACQ: begin
            if (bit_fall && fall_num == `SADC_START_FALL) begin
               next_state = SADC_START;
            end
         end
         SADC_START: begin
            if (bit_fall) begin
               next_state = SADC_CONV;
            end
         end
         SADC_CONV: begin
            if (bit_fall && fall_num == `SADC_LSB_FALL) begin
               // Conversion is complete once the LSB is decided
               next_state = SADC_REPEAT;
            end
         end
         SADC_REPEAT: begin
            if (bit_fall && fall_num == `SADC_TRIST_FALL) begin
               next_state = SADC_DONE;
            end
         end
         SADC_DONE: begin
            next_state = SADC_DONE;
         end
      endcase
      // Select high aborts any phase and powers down
      if (cs_n_i) begin
         next_state = SADC_IDLE;
      end
   end

   // Serial output: data changes are launched by a falling clock edge; select high releases the line at once
   always_comb begin
      next_dout = dout_o;
      next_oe_n = dout_oe_n_o;
      if (cs_n_i) begin
         next_oe_n = 1'b1;
      end else if (bit_fall && fall_num == `SADC_START_FALL) begin
         next_dout = 1'b0;
         next_oe_n = 1'b0;
      end else if (conv_fall) begin
         // Bit goes out in the cycle it is decided, no pipeline
         next_dout = cmp_i;
      end else if (rep_fall) begin
         next_dout = result[rep_idx];
      end else if (bit_fall && fall_num == `SADC_TRIST_FALL) begin
         next_oe_n = 1'b1;
      end
   end

   // State registers
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= SADC_IDLE;
         cnt <= `SADC_CNT_ZERO;
         dout_o <= 1'b0;
         dout_oe_n_o <= 1'b1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         dout_o <= next_dout;
         dout_oe_n_o <= next_oe_n;
      end
   end

   // Checks on the sequencer
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_start_edge;
      state == SADC_ACQ && bit_fall && fall_num == `SADC_START_FALL;
   endsequence

   sequence s_lsb_edge;
      bit_fall && fall_num == `SADC_LSB_FALL;
   endsequence

   // First repeat fall, right after the LSB decision
   sequence s_rep_edge;
      bit_fall && fall_num == `SADC_LSB_FALL + `SADC_CNT_ONE;
   endsequence

   // Fall that repeats the MSB
   sequence s_last_edge;
      bit_fall && fall_num == `SADC_LAST_FALL;
   endsequence

   // Fall that releases the line
   sequence s_trist_edge;
      bit_fall && fall_num == `SADC_TRIST_FALL;
   endsequence

   AST_LAUNCH_ON_FALL: assert property (
      !$past(bit_fall) && !$past(cs_n_i) |-> $stable(dout_o))
      else $error("Serial data changed without a falling clock edge");

   AST_CS_FALL_STARTS: assert property (
      state == SADC_IDLE && cs_fall |=> state == SADC_ACQ && sample_o)
      else $error("Select fall did not start acquisition");

   AST_ACQ_QUIET: assert property (
      state == SADC_ACQ |-> dout_oe_n_o && cnt < `SADC_START_FALL)
      else $error("Output driven during acquisition");

   AST_START_BIT: assert property (
      s_start_edge |=> !dout_o && !dout_oe_n_o && state == SADC_START)
      else $error("Start bit not driven low on fifth fall");

   AST_MSB_FIRST: assert property (
      state == SADC_START && bit_fall |=> dout_o == $past(cmp_i) && result[15] == dout_o)
      else $error("MSB not sent right after start bit");

   AST_REPEAT_LSB_FIRST: assert property (
      s_lsb_edge ##[1:1000] s_rep_edge |=> dout_o == result[1])
      else $error("Repeat did not begin with bit one");

   AST_TRISTATE_DONE: assert property (
      state == SADC_DONE |-> dout_oe_n_o && !analog_pwr_o)
      else $error("Output driven after repeated MSB");

   AST_NO_RESTART: assert property (
      state == SADC_DONE && !cs_n_i |=> state == SADC_DONE)
      else $error("Conversion restarted without select toggle");

   AST_ANALOG_OFF_AFTER_LSB: assert property (
      ((state == SADC_CONV) and s_lsb_edge) |=> !analog_pwr_o)
      else $error("Analog section not powered down after conversion");

   AST_ABORT: assert property (
      cs_n_i |-> !digital_pwr_o ##1
         (state == SADC_IDLE && cnt == `SADC_CNT_ZERO && dout_oe_n_o))
      else $error("Select high did not abort and clear");

   // Falls one to four only count; the output stays released while sampling
   AST_ACQ_FALLS_SILENT: assert property (
      bit_fall && fall_num < `SADC_START_FALL |=> dout_oe_n_o && sample_o)
      else $error("Output enabled before the fifth falling edge");

   // Start bit stands a full period until the next counted fall
   AST_START_HOLDS: assert property (
      state == SADC_START && !bit_fall && !cs_n_i |=> !dout_o && !dout_oe_n_o)
      else $error("Start bit did not stand for its period");

   // The sixteenth decided bit is the LSB
   AST_LSB_LAST: assert property (
      s_lsb_edge |=> dout_o == $past(cmp_i) && result[0] == dout_o)
      else $error("LSB not sent on the last conversion fall");

   // The result register records exactly what the comparator decided
   AST_STRAIGHT_BINARY: assert property (
      conv_fall |=> result[$past(conv_idx)] == $past(cmp_i))
      else $error("Result bit differs from comparator decision");

   // No pipeline: a bit decided on a fall is on the line the next cycle
   AST_NO_PIPELINE: assert property (
      conv_fall |=> dout_o == $past(cmp_i) && !dout_oe_n_o)
      else $error("Decided bit not presented at once");

   // Analog stays powered while bits are still being decided
   AST_ANALOG_HELD: assert property (
      conv_fall && fall_num != `SADC_LSB_FALL |=> analog_pwr_o)
      else $error("Analog section dropped before the LSB decision");

   // Low select after conversion keeps only the digital section awake
   AST_DIGITAL_AWAKE: assert property (
      state == SADC_DONE && !cs_n_i |-> digital_pwr_o && !analog_pwr_o)
      else $error("Power split wrong with select low after conversion");

   // Last repeat fall puts the MSB on the line once more
   AST_MSB_REPEATED: assert property (
      s_last_edge |=> dout_o == result[15] && !dout_oe_n_o)
      else $error("MSB not repeated last");

   // The fall after the repeated MSB releases the line for good
   AST_TRISTATE_EDGE: assert property (
      s_last_edge ##[1:1000] s_trist_edge |=> dout_oe_n_o && state == SADC_DONE)
      else $error("Line not released after repeated MSB");

   // Clocks in the finished phase change nothing
   AST_DONE_IGNORES_CLOCK: assert property (
      state == SADC_DONE && clk_fall_raw && !cs_n_i |=> $stable(cnt) && dout_oe_n_o)
      else $error("Clock after conversion changed the sequencer");

   // Select held low never falls back to a fresh start
   AST_HOLD_LOW_NO_RESTART: assert property (
      state != SADC_IDLE && !cs_n_i |=> state != SADC_IDLE)
      else $error("Sequencer restarted while select stayed low");

   // Release of select clears counter and trial word for the next frame
   AST_RISE_CLEARS: assert property (
      cs_rise |=> state == SADC_IDLE && cnt == `SADC_CNT_ZERO &&
         dac_code_o == `SADC_TRIAL_INIT)
      else $error("Select release did not clear the sequencer");
endmodule

// ==== logic/sadc_regs.svh ====
// Timing and width constants of the serial converter readout
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH
`define SADC_RES_W 16
`define SADC_CNT_W 6
`define SADC_IDX_W 4
`define SADC_CNT_ZERO 6'h00
`define SADC_CNT_ONE 6'h01
`define SADC_START_FALL 6'h05
`define SADC_MSB_FALL 6'h06
`define SADC_LSB_FALL 6'h15
`define SADC_LAST_FALL 6'h24
`define SADC_TRIST_FALL 6'h25
`define SADC_TRIAL_INIT 16'h8000
`define SADC_RESULT_INIT 16'h0000
`endif

// ==== logic/sadc_pkg.sv ====
// Types shared by the serial converter readout files
package sadc_pkg;
   // Sequencer phases of one select-low period
   typedef enum logic [2:0] {
      SADC_IDLE,
      SADC_ACQ,
      SADC_START,
      SADC_CONV,
      SADC_REPEAT,
      SADC_DONE
   } sadc_state_t;
endpackage

// ==== logic/sadc_edge.sv ====
// Edge detector for a signal already synchronous to the system clock
`timescale 1ns/1ps
module sadc_edge (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic sig_i,
   input wire logic reset_level_i,
   output logic rise_o,
   output logic fall_o
);
   logic prev; // Last sampled level

   // Remember the level of the previous cycle; reset always loads high
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev <= 1'b1;
      end else begin
         prev <= sig_i;
      end
   end

   // Edges are plain compares; the input is not a raw asynchronous pin
   assign rise_o = sig_i & ~prev & ~reset_level_i;
   assign fall_o = ~sig_i & prev;
endmodule

// ==== logic/sadc_sar.sv ====
// Successive approximation register holding trial code and result
`timescale 1ns/1ps
`include "sadc_regs.svh"
module sadc_sar
   import sadc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clear_i,
   input wire logic decide_i,
   input wire logic [`SADC_IDX_W-1:0] bit_idx_i,
   input wire logic cmp_i,
   output logic [`SADC_RES_W-1:0] trial_o,
   output logic [`SADC_RES_W-1:0] result_o
);
   localparam logic [`SADC_RES_W-1:0] TRIAL_INIT = `SADC_TRIAL_INIT; // Trial word after clear
   genvar gi;

   // One slice per bit: decide own bit, then arm the next lower trial bit
   generate
      for (gi = 0; gi < `SADC_RES_W; gi = gi + 1) begin : g_bit
         wire this_bit = decide_i && (bit_idx_i == `SADC_IDX_W'(gi));
         wire next_bit = decide_i && (gi < `SADC_RES_W - 1) &&
                         (bit_idx_i == `SADC_IDX_W'(gi + 1));
         always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               trial_o[gi] <= TRIAL_INIT[gi];
               result_o[gi] <= 1'b0;
            end else if (clear_i) begin
               trial_o[gi] <= TRIAL_INIT[gi];
               result_o[gi] <= 1'b0;
            end else if (this_bit) begin
               // Straight binary: comparator high keeps the bit set
               trial_o[gi] <= cmp_i;
               result_o[gi] <= cmp_i;
            end else if (next_bit) begin
               trial_o[gi] <= 1'b1;
            end
         end
      end
   endgenerate
endmodule

// ==== tb/sadc_host.sv ====
// Host serial master model that clocks one conversion frame out of the readout
`timescale 1ns/1ps
module sadc_host (
   input wire logic sys_clk_i,
   output logic serial_bit_clock_o,
   output logic cs_n_o,
   input wire logic dout_i,
   input wire logic dout_oe_n_i,
   input wire logic sample_i,
   input wire logic apwr_i,
   input wire logic dpwr_i
);
   logic wire_lvl; // Level the host really sees on the data line
   logic [4:0] rec [1:40]; // Per period: digital pwr, sample, analog pwr, oe_n, data
   initial begin
      serial_bit_clock_o = 1'b1;
      cs_n_o = 1'b1;
   end
   // No pull on the line, so a released line shows the inverse of the last bit
   assign wire_lvl = dout_oe_n_i ? ~dout_i : dout_i;
   // One frame of n clock periods; the clock idles high outside frames
   task automatic run(input int n);
      int p;
      @(posedge sys_clk_i) cs_n_o <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      for (p = 1; p <= n; p++) begin
         @(posedge sys_clk_i) serial_bit_clock_o <= 1'b0;
         // Low for three cycles so the launched bit has settled
         repeat (3) @(posedge sys_clk_i);
         serial_bit_clock_o <= 1'b1;
         rec[p] = {dpwr_i, sample_i, apwr_i, dout_oe_n_i, wire_lvl};
         @(posedge sys_clk_i);
      end
      cs_n_o <= 1'b1;
   endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the serial converter readout sequencer
`timescale 1ns/1ps
module testbench;
   logic sys_clk_i;
   logic rst_n_i;
   logic [15:0] target; // Input level the comparator model converts
   logic [15:0] dac_code;
   logic cmp;
   logic sclk;
   logic cs_n;
   logic dout;
   logic oe_n;
   logic smp;
   logic apwr;
   logic dpwr;
   int failures = 0;
   int total_checks = 0;
   int seed = 58212;
   int i;
   logic [15:0] hand [5] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff, 16'h5555}; // Corners
   int cut [3] = '{3, 4, 14}; // Short cycle lengths
   initial sys_clk_i = 1'b0;
   // 10 MHz system clock
   always #50 sys_clk_i = ~sys_clk_i;
   // Ideal comparator: high while the input is at or above the trial code
   assign cmp = (target >= dac_code);
   sadc_readout u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .serial_bit_clock_i(sclk),
      .cs_n_i(cs_n), .cmp_i(cmp), .dac_code_o(dac_code), .sample_o(smp),
      .analog_pwr_o(apwr), .digital_pwr_o(dpwr), .dout_o(dout), .dout_oe_n_o(oe_n));
   sadc_host u_host (.sys_clk_i(sys_clk_i), .serial_bit_clock_o(sclk), .cs_n_o(cs_n),
      .dout_i(dout), .dout_oe_n_i(oe_n), .sample_i(smp), .apwr_i(apwr), .dpwr_i(dpwr));
   // Expected host view at the rise of period p for result code c
   function automatic logic [4:0] expv(input int p, input logic [15:0] c);
      logic d;
      logic off;
      off = !(p >= 5 && p <= 36);
      d = 1'b0;
      if (p >= 6 && p <= 21) begin
         d = c[21-p];
      end
      if (p >= 22 && p <= 36) begin
         d = c[p-21];
      end
      return {1'b1, p <= 4, p <= 20, off, d};
   endfunction
   // Compare and count
   task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   // One frame of n periods, then select high and the idle state
   task automatic frame(input logic [15:0] c, input int n);
      logic [4:0] e;
      logic [4:0] g;
      int p;
      @(posedge sys_clk_i) target <= c;
      u_host.run(n);
      for (p = 1; p <= n; p++) begin
         e = expv(p, c);
         g = u_host.rec[p];
         // Data bit is meaningless while the line is released
         if (e[1]) begin
            g[0] = e[0];
         end
         check("period view", 16'(e), 16'(g));
      end
      repeat (3) @(posedge sys_clk_i);
      check("idle power", 16'h0001, 16'({dpwr, smp, apwr, oe_n}));
      $display("Test code %h periods %0d done", c, n);
   endtask
   // Verdict and end of run
   task automatic summarize();
      $display("Checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Main sequence: corner codes, random codes, aborted frames
   initial begin
      rst_n_i = 1'b0;
      target = 16'h0000;
      repeat (20) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      // Forty periods keep clocking after tri-state, select still low
      for (i = 0; i < 5; i++) begin
         frame(hand[i], 40);
      end
      for (i = 0; i < 4; i++) begin
         frame(16'($random(seed)), 40);
      end
      // Abort mid-frame, then a full frame must start from acquisition
      for (i = 0; i < 3; i++) begin
         frame(16'($random(seed)), cut[i]);
         frame(16'($random(seed)), 40);
      end
      summarize();
   end
   // Watchdog far beyond the roughly 2600 cycles the tests need
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      failures++;
      summarize();
   end
endmodule
